// File: inc/usf_pkg.sv
// Constants, types and helpers of the flow-control block
package usf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_EFC   = 8'h00;
  localparam logic [7:0] OFF_TXTHR = 8'h04;
  localparam logic [7:0] OFF_RES1  = 8'h08;
  localparam logic [7:0] OFF_RES2  = 8'h0c;
  localparam logic [7:0] OFF_PAU1  = 8'h10;
  localparam logic [7:0] OFF_PAU2  = 8'h14;
  localparam logic [7:0] OFF_IEM   = 8'h18;
  localparam logic [7:0] OFF_IST   = 8'h1c;
  localparam logic [7:0] OFF_FFC   = 8'h20;
  localparam logic [7:0] OFF_MDC   = 8'h24;
  localparam logic [7:0] OFF_STAT  = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and guarded masks
  localparam int unsigned ENH_BIT      = 4;
  localparam int unsigned SPEC_BIT     = 5;
  localparam int unsigned IST_TX_BIT   = 1;
  localparam int unsigned IST_SPEC_BIT = 4;
  localparam int unsigned IST_FLOW_BIT = 5;
  localparam logic [7:0]  IEM_GUARD    = 8'hf0;
  localparam logic [7:0]  IST_GUARD    = 8'h30;
  localparam logic [7:0]  FFC_GUARD    = 8'h30;
  localparam logic [7:0]  MDC_GUARD    = 8'he0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and bus codes
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] SHADOW_TAG  = 8'ha5;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] LEVEL_MIN   = 8'h01;
  localparam logic [7:0] LEVEL_MAX   = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Pair selection of each direction
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_SECOND = 2'b01,
    SEL_FIRST  = 2'b10,
    SEL_BOTH   = 2'b11
  } usf_sel_t;

  // Codes 0 and 1 give level 1; above 128 clamps
  function automatic logic [7:0] trig_level(input logic [7:0] code);
    logic [7:0] lvl;
    lvl = code;
    if (code < LEVEL_MIN) lvl = LEVEL_MIN;
    if (code > LEVEL_MAX) lvl = LEVEL_MAX;
    return lvl;
  endfunction : trig_level

  // Guarded bits hold unless enabled
  function automatic logic [7:0] guard_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] mask,
                                             input logic       en);
    return en ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction : guard_merge

endpackage : usf_pkg

// File: hdl/usf_rx_match.sv
// Receive compare against flow and special characters
`timescale 1ns/1ns
module usf_rx_match (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  // Configuration
  input  wire usf_pkg::usf_sel_t rx_sel,
  input  wire logic            seq_mode,
  input  wire logic            spec_en,
  input  wire logic [7:0]      res1,
  input  wire logic [7:0]      res2,
  input  wire logic [7:0]      pau1,
  input  wire logic [7:0]      pau2,
  // Received character
  input  wire logic            char_valid,
  input  wire logic [7:0]      char_data,
  // Decisions, same cycle
  output logic                 is_ctrl,
  output logic                 got_pause,
  output logic                 got_resume,
  output logic                 got_special
);

  typedef struct packed {
    logic res_seen;
    logic pau_seen;
  } usf_match_st_t;

  usf_match_st_t s_q;
  usf_match_st_t s_d;

  logic m_r1;
  logic m_r2;
  logic m_p1;
  logic m_p2;
  logic use1;
  logic use2;

  // Bit 0 of stored character meets received LSB
  assign m_r1 = (char_data == res1);
  assign m_r2 = (char_data == res2);
  assign m_p1 = (char_data == pau1);
  assign m_p2 = (char_data == pau2);
  assign use1 = rx_sel[1];
  assign use2 = rx_sel[0];

  always_comb begin
    s_d         = s_q;
    got_pause   = 1'b0;
    got_resume  = 1'b0;
    is_ctrl     = 1'b0;
    got_special = char_valid && spec_en && m_p2;
    if (char_valid) begin
      is_ctrl = (use1 && (m_r1 || m_p1)) || (use2 && (m_r2 || m_p2));
      if (rx_sel == usf_pkg::SEL_BOTH && seq_mode) begin
        // Sequences: first then second
        got_resume = m_r2 && s_q.res_seen;
        got_pause  = m_p2 && s_q.pau_seen;
        s_d.res_seen = m_r1;
        s_d.pau_seen = m_p1;
      end else begin
        got_resume = (use1 && m_r1) || (use2 && m_r2);
        got_pause  = (use1 && m_p1) || (use2 && m_p2);
        s_d.res_seen = 1'b0;
        s_d.pau_seen = 1'b0;
      end
    end
    if (rx_sel != usf_pkg::SEL_BOTH) begin
      s_d.res_seen = 1'b0;
      s_d.pau_seen = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : usf_rx_match

// File: hdl/usf_tx_flow.sv
// Sequencer for outgoing pause and resume characters
`timescale 1ns/1ns
module usf_tx_flow (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  // Configuration
  input  wire usf_pkg::usf_sel_t tx_sel,
  input  wire logic [7:0]      res1,
  input  wire logic [7:0]      res2,
  input  wire logic [7:0]      pau1,
  input  wire logic [7:0]      pau2,
  // Requests from receive fill logic
  input  wire logic            send_pause,
  input  wire logic            send_resume,
  // Character out to transmitter
  input  wire logic            out_ready,
  output logic                 out_valid,
  output logic [7:0]           out_char
);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ONE  = 2'b01,
    TX_TWO  = 2'b10
  } usf_txst_t;

  typedef struct packed {
    usf_txst_t  st;
    logic       pend_pause;
    logic       pend_resume;
    logic       is_pause;
    logic       valid;
    logic [7:0] data;
  } usf_tx_st_t;

  usf_tx_st_t s_q;
  usf_tx_st_t s_d;

  assign out_valid = s_q.valid;
  assign out_char  = s_q.data;

  always_comb begin
    s_d = s_q;
    // Newest request replaces the opposite one
    if (send_pause) begin
      s_d.pend_pause  = 1'b1;
      s_d.pend_resume = 1'b0;
    end else if (send_resume) begin
      s_d.pend_resume = 1'b1;
      s_d.pend_pause  = 1'b0;
    end
    unique case (s_q.st)
      TX_IDLE: begin
        if (tx_sel == usf_pkg::SEL_NONE) begin
          s_d.pend_pause  = 1'b0;
          s_d.pend_resume = 1'b0;
        end else if (s_q.pend_pause || s_q.pend_resume) begin
          s_d.is_pause = s_q.pend_pause;
          if (s_q.pend_pause) begin
            s_d.pend_pause = send_pause;
          end else begin
            s_d.pend_resume = send_resume;
          end
          s_d.valid = 1'b1;
          s_d.st    = TX_ONE;
          if (tx_sel == usf_pkg::SEL_SECOND) begin
            s_d.data = s_q.pend_pause ? pau2 : res2;
          end else begin
            s_d.data = s_q.pend_pause ? pau1 : res1;
          end
        end
      end
      TX_ONE: begin
        if (out_ready) begin
          if (tx_sel == usf_pkg::SEL_BOTH) begin
            s_d.data = s_q.is_pause ? pau2 : res2;
            s_d.st   = TX_TWO;
          end else begin
            s_d.valid = 1'b0;
            s_d.st    = TX_IDLE;
          end
        end
      end
      TX_TWO: begin
        if (out_ready) begin
          s_d.valid = 1'b0;
          s_d.st    = TX_IDLE;
        end
      end
      default: begin
        s_d.valid = 1'b0;
        s_d.st    = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: TX_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : usf_tx_flow

// File: hdl/usf_ctrl.sv
// Enhanced-feature and flow control registers behind AXI4-Lite
//
// Overview of operation
// - Special detect stores a second-pause match and flags status bit 4.
// - Flow chars compare bit for bit, bit 0 to the received LSB.
// - Special detect is off after reset.
// - Register writes change guarded bits only while the enhanced enable is one.
// - Setting the enhanced enable restores settings kept across reset.
// - The flow selection resets to zero.
// - Upper selection bits pick transmit: none, first, second or both pairs.
// - Lower selection bits pick receive compare: none, first, second or both pairs.
// - Codes 1011 and 0111 accept either pair; 1111 needs both in sequence.
// - Flow chars are control, not payload, while flow control is on.
// - The transmit threshold sets the transmit interrupt level in 128-byte mode.
// - Threshold codes 0 and 1 mean level 1, 0x80 means 128.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module usf_ctrl #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,

  // AXI4-Lite write address
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,

  // AXI4-Lite write data
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,

  // AXI4-Lite write response
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  output logic [1:0]             s_axil_bresp,

  // AXI4-Lite read
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,

  // Receive character stream
  input  wire logic              rx_char_valid,
  input  wire logic [7:0]        rx_char_data,
  output logic                   rx_store_valid,
  output logic [7:0]             rx_store_data,

  // Transmit flow characters
  input  wire logic              flow_pause_req,
  input  wire logic              flow_resume_req,
  input  wire logic              flow_char_ready,
  output logic                   flow_char_valid,
  output logic [7:0]             flow_char_data,

  // Transmit FIFO state
  input  wire logic [7:0]        tx_fifo_level,
  input  wire logic              fifo_128_mode,

  // Status out
  output logic                   tx_halted,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0]        wbyte;
    logic              wlane;

    logic              bvalid;
    logic [1:0]        bresp;

    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;

    logic [7:0]        efc;
    logic [7:0]        txthr;
    logic [7:0]        res1;
    logic [7:0]        res2;
    logic [7:0]        pau1;
    logic [7:0]        pau2;
    logic [7:0]        iem;
    logic [7:0]        ist;
    logic [7:0]        ffc;
    logic [7:0]        mdc;

    logic              tx_halt;
    logic              tx_cond;
    logic              store_valid;
    logic [7:0]        store_data;
    logic              irq;
  } usf_ctrl_st_t;

  // Survives reset, so it has none
  typedef struct packed {
    logic [7:0] tag;
    logic [7:0] iem;
    logic [7:0] ffc;
    logic [7:0] mdc;
  } usf_shadow_t;

  usf_ctrl_st_t s_q;
  usf_ctrl_st_t s_d;
  usf_shadow_t  sh_q;
  usf_shadow_t  sh_d;

  logic m_ctrl;
  logic m_pause;
  logic m_resume;
  logic m_special;
  logic tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  usf_pkg::usf_sel_t rx_sel;
  usf_pkg::usf_sel_t tx_sel;

  assign tx_sel = usf_pkg::usf_sel_t'(s_q.efc[3:2]);
  assign rx_sel = usf_pkg::usf_sel_t'(s_q.efc[1:0]);

  usf_rx_match u_rx_match (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .rx_sel      (rx_sel),
    .seq_mode    (tx_sel == usf_pkg::SEL_BOTH),
    .spec_en     (s_q.efc[usf_pkg::SPEC_BIT]),
    .res1        (s_q.res1),
    .res2        (s_q.res2),
    .pau1        (s_q.pau1),
    .pau2        (s_q.pau2),
    .char_valid  (rx_char_valid),
    .char_data   (rx_char_data),
    .is_ctrl     (m_ctrl),
    .got_pause   (m_pause),
    .got_resume  (m_resume),
    .got_special (m_special)
  );

  usf_tx_flow u_tx_flow (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .tx_sel      (tx_sel),
    .res1        (s_q.res1),
    .res2        (s_q.res2),
    .pau1        (s_q.pau1),
    .pau2        (s_q.pau2),
    .send_pause  (flow_pause_req),
    .send_resume (flow_resume_req),
    .out_ready   (flow_char_ready),
    .out_valid   (flow_char_valid),
    .out_char    (flow_char_data)
  );

  assign tx_busy = flow_char_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       enh;
    logic       tx_now;
    logic [7:0] clr;
    logic [7:0] rd;
    logic       hit;

    enh    = s_q.efc[usf_pkg::ENH_BIT];
    tx_now = 1'b0;
    clr    = '0;
    rd     = '0;
    hit    = 1'b1;
    s_d    = s_q;
    sh_d   = sh_q;

    // Responses leave on their handshake
    if (s_axil_bready) s_d.bvalid = 1'b0;
    if (s_axil_rready) s_d.rvalid = 1'b0;

    // Address and data in either order
    if (s_axil_awvalid && s_q.awready) begin
      s_d.awaddr = s_axil_awaddr;
      s_d.aw_got = 1'b1;
    end
    if (s_axil_wvalid && s_q.wready) begin
      s_d.wbyte  = s_axil_wdata[7:0];
      s_d.wlane  = s_axil_wstrb[0];
      s_d.w_got  = 1'b1;
    end

    // Write once both halves are held
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = usf_pkg::RESP_OKAY;
      unique case (s_q.awaddr)
        usf_pkg::OFF_EFC: begin
          if (s_q.wlane) begin
            s_d.efc = s_q.wbyte;
            if (!enh && s_q.wbyte[usf_pkg::ENH_BIT] &&
                sh_q.tag == usf_pkg::SHADOW_TAG) begin
              s_d.iem = usf_pkg::guard_merge(sh_q.iem, s_q.iem, usf_pkg::IEM_GUARD, 1'b0);
              s_d.ffc = usf_pkg::guard_merge(sh_q.ffc, s_q.ffc, usf_pkg::FFC_GUARD, 1'b0);
              s_d.mdc = usf_pkg::guard_merge(sh_q.mdc, s_q.mdc, usf_pkg::MDC_GUARD, 1'b0);
            end
          end
        end
        usf_pkg::OFF_TXTHR: if (s_q.wlane) s_d.txthr = s_q.wbyte;
        usf_pkg::OFF_RES1:  if (s_q.wlane) s_d.res1 = s_q.wbyte;
        usf_pkg::OFF_RES2:  if (s_q.wlane) s_d.res2 = s_q.wbyte;
        usf_pkg::OFF_PAU1:  if (s_q.wlane) s_d.pau1 = s_q.wbyte;
        usf_pkg::OFF_PAU2:  if (s_q.wlane) s_d.pau2 = s_q.wbyte;
        usf_pkg::OFF_IEM: begin
          if (s_q.wlane) s_d.iem = usf_pkg::guard_merge(s_q.iem, s_q.wbyte,
                                                       usf_pkg::IEM_GUARD, enh);
        end
        usf_pkg::OFF_IST: begin
          if (s_q.wlane) clr = s_q.wbyte & (enh ? 8'hff : ~usf_pkg::IST_GUARD);
        end
        usf_pkg::OFF_FFC: begin
          if (s_q.wlane) s_d.ffc = usf_pkg::guard_merge(s_q.ffc, s_q.wbyte,
                                                       usf_pkg::FFC_GUARD, enh);
        end
        usf_pkg::OFF_MDC: begin
          if (s_q.wlane) s_d.mdc = usf_pkg::guard_merge(s_q.mdc, s_q.wbyte,
                                                       usf_pkg::MDC_GUARD, enh);
        end
        usf_pkg::OFF_STAT: ;
        default:           s_d.bresp = usf_pkg::RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;

    // Register read
    if (s_axil_arvalid && s_q.arready) begin
      unique case (s_axil_araddr)
        usf_pkg::OFF_EFC:   rd = s_q.efc;
        usf_pkg::OFF_TXTHR: rd = s_q.txthr;
        usf_pkg::OFF_RES1:  rd = s_q.res1;
        usf_pkg::OFF_RES2:  rd = s_q.res2;
        usf_pkg::OFF_PAU1:  rd = s_q.pau1;
        usf_pkg::OFF_PAU2:  rd = s_q.pau2;
        usf_pkg::OFF_IEM:   rd = s_q.iem;
        usf_pkg::OFF_IST:   rd = s_q.ist;
        usf_pkg::OFF_FFC:   rd = s_q.ffc;
        usf_pkg::OFF_MDC:   rd = s_q.mdc;
        usf_pkg::OFF_STAT:  rd = {5'h00, enh, tx_busy, s_q.tx_halt};
        default:            hit = 1'b0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h000000, rd};
      s_d.rresp  = hit ? usf_pkg::RESP_OKAY : usf_pkg::RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;

    // Shadow follows guarded bits while enabled
    if (s_d.efc[usf_pkg::ENH_BIT]) begin
      sh_d.tag = usf_pkg::SHADOW_TAG;
      sh_d.iem = s_d.iem;
      sh_d.ffc = s_d.ffc;
      sh_d.mdc = s_d.mdc;
    end

    // Status clear first, so a same-cycle event wins
    s_d.ist = s_q.ist & ~clr;

    // Control characters are not stored unless special
    s_d.store_valid = rx_char_valid && (!m_ctrl || m_special);
    s_d.store_data  = rx_char_data;
    if (m_special) s_d.ist[usf_pkg::IST_SPEC_BIT] = 1'b1;
    if (m_pause || m_resume) s_d.ist[usf_pkg::IST_FLOW_BIT] = 1'b1;

    // Remote pause halts transmit until resume or receive selection none
    if (m_pause) s_d.tx_halt = 1'b1;
    if (m_resume || rx_sel == usf_pkg::SEL_NONE) s_d.tx_halt = 1'b0;

    // Transmit level event on entering the condition
    if (fifo_128_mode) begin
      tx_now = (usf_pkg::LEVEL_MAX - tx_fifo_level) >= usf_pkg::trig_level(s_q.txthr);
    end else begin
      tx_now = (tx_fifo_level == 8'h00);
    end
    s_d.tx_cond = tx_now;
    if (tx_now && !s_q.tx_cond) s_d.ist[usf_pkg::IST_TX_BIT] = 1'b1;

    s_d.irq = |(s_d.ist & s_d.iem);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q     <= '0;
      s_q.efc <= usf_pkg::REG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk) begin
    sh_q <= sh_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axil_awready = s_q.awready;
  assign s_axil_wready  = s_q.wready;
  assign s_axil_bvalid  = s_q.bvalid;
  assign s_axil_bresp   = s_q.bresp;
  assign s_axil_arready = s_q.arready;
  assign s_axil_rvalid  = s_q.rvalid;
  assign s_axil_rdata   = s_q.rdata;
  assign s_axil_rresp   = s_q.rresp;

  assign rx_store_valid = s_q.store_valid;
  assign rx_store_data  = s_q.store_data;
  assign tx_halted      = s_q.tx_halt;
  assign irq            = s_q.irq;

endmodule : usf_ctrl

// File: verification/usf_ctrl_properties.sv
// Port-level properties of the flow-control block
`timescale 1ns/1ns
module usf_ctrl_properties (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wready,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_arready,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  // Streams and status
  input wire logic        rx_char_valid,
  input wire logic [7:0]  rx_char_data,
  input wire logic        rx_store_valid,
  input wire logic [7:0]  rx_store_data,
  input wire logic        flow_char_valid,
  input wire logic [7:0]  flow_char_data,
  input wire logic        flow_char_ready,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  a_store_source: assert property (
    rx_store_valid |-> $past(rx_char_valid) && rx_store_data == $past(rx_char_data))
    else $error("store not from received char");
  a_store_gap: assert property (
    !rx_char_valid |=> !rx_store_valid) else $error("store without char");
  a_flow_hold: assert property (
    flow_char_valid && !flow_char_ready |=> flow_char_valid && $stable(flow_char_data))
    else $error("flow char dropped");
  a_bresp_hold: assert property (
    s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped");
  a_b_after_take: assert property (
    $rose(s_axil_bvalid) |-> !s_axil_awready && !s_axil_wready)
    else $error("response before write taken");
  a_r_release: assert property (
    s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid) else $error("read not released");
  a_ar_blocked: assert property (
    s_axil_rvalid |-> !s_axil_arready) else $error("read taken while busy");
  a_rdata_upper: assert property (
    s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000) else $error("upper data set");
  c_store: cover property (rx_store_valid);
  c_flow: cover property (flow_char_valid && flow_char_ready);
  c_irq: cover property (irq);
endmodule : usf_ctrl_properties
bind usf_ctrl usf_ctrl_properties chk_u (.*);

// File: verification/usf_remote_station.sv
// Remote station model: sends line characters, takes flow characters
`timescale 1ns/1ns
module usf_remote_station (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Bench commands
  input wire logic       send_go,
  input wire logic [7:0] send_char,
  input wire logic       stall,
  // Line side
  output logic           rx_char_valid,
  output logic [7:0]     rx_char_data,
  input wire logic       flow_char_valid,
  input wire logic [7:0] flow_char_data,
  output logic           flow_char_ready,
  // Flow characters taken as control
  output logic [7:0]     flow_seen,
  output logic [7:0]     flow_count
);
  assign flow_char_ready = !stall;
  // Idle data toggles so no stale character is seen
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_char_valid <= 1'b0;
      rx_char_data <= 8'h00;
      flow_seen <= 8'h00;
      flow_count <= 8'h00;
    end else begin
      rx_char_valid <= send_go;
      rx_char_data <= send_go ? send_char : ~rx_char_data;
      if (flow_char_valid && flow_char_ready) begin
        flow_seen <= flow_char_data;
        flow_count <= flow_count + 8'h01;
      end
    end
  end
endmodule : usf_remote_station

// File: verification/tb.sv
// Self-checking bench of the flow-control block
`timescale 1ns/1ns
module tb;
  logic core_clk, rst_b, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic s_axil_rready, rx_char_valid, rx_store_valid, flow_pause_req, flow_resume_req;
  logic flow_char_ready, flow_char_valid, fifo_128_mode, tx_halted, irq, send_go, stall;
  logic [7:0] s_axil_awaddr, s_axil_araddr, rx_char_data, rx_store_data, flow_char_data;
  logic [7:0] tx_fifo_level, send_char, flow_seen, flow_count;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  int failures, samples_checked, cycles;
  usf_ctrl #(.ADDR_W(8)) dut_u (.*);
  usf_remote_station peer_u (.*);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = 2'b00);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h000000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk("bresp", er, s_axil_bresp);
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input logic [1:0] er = 2'b00);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    chk($sformatf("reg %h", a), {24'h000000, e}, s_axil_rdata);
    chk("rresp", er, s_axil_rresp);
    @(posedge core_clk);
  endtask : rd
  task automatic rxs(input logic [7:0] a, b, input int n, input logic h);
    int k;
    k = 0;
    send_char <= a;
    send_go <= 1'b1;
    @(posedge core_clk);
    send_char <= b;
    @(posedge core_clk);
    send_go <= 1'b0;
    repeat (6) begin
      @(posedge core_clk);
      if (rx_store_valid === 1'b1) k++;
    end
    chk("stores", n, k);
    chk("tx_halted", h, tx_halted);
  endtask : rxs
  task automatic txf(input logic [1:0] s, input logic r, input int n, input logic [7:0] e);
    logic [7:0] c0;
    wr(8'h00, {4'h0, s, 2'b00});
    c0 = flow_count;
    stall <= 1'b1;
    flow_pause_req <= !r;
    flow_resume_req <= r;
    @(posedge core_clk);
    flow_pause_req <= 1'b0;
    flow_resume_req <= 1'b0;
    repeat (5) @(posedge core_clk);
    stall <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("flow count", n, flow_count - c0);
    chk("flow char", e, flow_seen);
  endtask : txf
  task automatic lv(input logic [7:0] v);
    tx_fifo_level <= v;
    repeat (3) @(posedge core_clk);
  endtask : lv
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a <= 'h28; a += 4) rd(8'(a), 8'h00);
    rd(8'h2c, 8'h00, 2'b10);
    wr(8'h2c, 8'h5a, 2'b10);
  endtask : t_reset
  task automatic t_restore;
    wr(8'h00, 8'h10);
    wr(8'h24, 8'he0);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(8'h24, 8'h00);
    wr(8'h00, 8'h10);
    rd(8'h24, 8'he0);
    wr(8'h00, 8'h00);
    wr(8'h24, 8'h1f);
    rd(8'h24, 8'hff);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h0f);
  endtask : t_restore
  task automatic t_special;
    for (int i = 0; i < 4; i++) wr(8'(8 + 4 * i), 8'(8'h11 + i));
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h30);
    rxs(8'h14, 8'h41, 2, 1'b0);
    rd(8'h1c, 8'h10);
    wr(8'h18, 8'h10);
    chk("irq", 1'b1, irq);
    wr(8'h18, 8'h00);
    chk("irq", 1'b0, irq);
    wr(8'h18, 8'h10);
    wr(8'h1c, 8'h10);
    rd(8'h1c, 8'h00);
    chk("irq", 1'b0, irq);
  endtask : t_special
  task automatic t_rxflow;
    wr(8'h00, 8'h02);
    rxs(8'h13, 8'h41, 1, 1'b1);
    rxs(8'hc8, 8'h14, 2, 1'b1);
    rxs(8'h11, 8'h41, 1, 1'b0);
    wr(8'h00, 8'h01);
    rxs(8'h13, 8'h14, 1, 1'b1);
    rxs(8'h12, 8'h11, 1, 1'b0);
    wr(8'h00, 8'h03);
    rxs(8'h14, 8'h41, 1, 1'b1);
    rxs(8'h11, 8'h13, 0, 1'b1);
    rxs(8'h12, 8'h41, 1, 1'b0);
    wr(8'h00, 8'h0f);
    rxs(8'h13, 8'h41, 1, 1'b0);
    rxs(8'h13, 8'h14, 0, 1'b1);
    rxs(8'h11, 8'h12, 0, 1'b0);
  endtask : t_rxflow
  task automatic t_txflow;
    txf(2'b00, 1'b0, 0, 8'h00);
    txf(2'b10, 1'b0, 1, 8'h13);
    txf(2'b01, 1'b0, 1, 8'h14);
    txf(2'b11, 1'b0, 2, 8'h14);
    txf(2'b10, 1'b1, 1, 8'h11);
  endtask : t_txflow
  task automatic t_txlvl;
    wr(8'h04, 8'h80);
    fifo_128_mode <= 1'b1;
    lv(8'h01);
    wr(8'h00, 8'h10);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    lv(8'h00);
    rd(8'h1c, 8'h02);
    lv(8'h80);
    wr(8'h04, 8'h00);
    wr(8'h1c, 8'h02);
    lv(8'h7f);
    rd(8'h1c, 8'h02);
    fifo_128_mode <= 1'b0;
    wr(8'h1c, 8'h02);
    lv(8'h80);
    lv(8'h01);
    rd(8'h1c, 8'h00);
  endtask : t_txlvl
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, rst_b, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready, flow_pause_req, flow_resume_req, send_go, stall} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, send_char, fifo_128_mode} = '0;
    s_axil_wstrb = 4'hf;
    tx_fifo_level = 8'h05;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_restore();
    t_special();
    t_rxflow();
    t_txflow();
    t_txlvl();
    test_done();
  end
endmodule : tb
